// File: hw/light_commissioning_pkg.sv
// Constants and types shared by the light commissioning logic
package light_commissioning_pkg;

   localparam int unsigned CLK_HZ           = 100_000_000;
   localparam int unsigned MS_CYCLES        = CLK_HZ / 1000;

   // Times in their own unit
   localparam int unsigned SEARCH_TIME_S    = 120;
   localparam int unsigned IDENTIFY_TIME_S  = 180;
   localparam int unsigned STATUS_TIME_S    = 30;
   localparam int unsigned BURST_WINDOW_MS  = 3000;
   localparam int unsigned SLOW_HALF_MS     = 1000;
   localparam int unsigned FAST_HALF_MS     = 250;
   localparam int unsigned SCAN_PERIOD_S    = 60;
   localparam int unsigned SCAN_ON_MS       = 1000;

   // Counts in milliseconds, stepped by a one-cycle tick
   localparam int unsigned SEARCH_MS        = SEARCH_TIME_S * 1000;
   localparam int unsigned IDENTIFY_MS      = IDENTIFY_TIME_S * 1000;
   localparam int unsigned STATUS_MS        = STATUS_TIME_S * 1000;
   localparam int unsigned SCAN_PERIOD_MS   = SCAN_PERIOD_S * 1000;

   // Flash counts
   localparam logic [4:0] JOIN_FLASHES      = 5'h0a;
   localparam logic [4:0] LEAVE_FLASHES     = 5'h03;

   // Burst counts
   localparam logic [3:0] BURST_IDENTIFY    = 4'h4;
   localparam logic [3:0] BURST_STATUS_LO   = 4'h5;
   localparam logic [3:0] BURST_STATUS_HI   = 4'h9;
   localparam logic [3:0] BURST_LEAVE       = 4'ha;

   // Reset values
   localparam logic [5:0] LIGHT_RESET       = 6'h00;

   typedef enum logic [2:0]
   {
      ST_OFF_NETWORK   = 3'h0,
      ST_ACTIVE_SEARCH = 3'h1,
      ST_JOIN          = 3'h2,
      ST_ON_NETWORK    = 3'h3,
      ST_IDENTIFY      = 3'h4,
      ST_STATUS        = 3'h5,
      ST_LEAVE         = 3'h6
   } commission_state_t;

endpackage

// File: hw/power_cycle_detect.sv
// Power-cycle event detector for button and supply-good inputs
`timescale 1ns/1ps
`default_nettype none

module power_cycle_detect
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Pins
   input  wire logic power_cycle_button,
   input  wire logic supply_good,
   // Events
   output logic      power_cycle
);

   logic [2:0] button_sync;
   logic [2:0] supply_sync;
   logic       button_state;
   logic       supply_state;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         button_sync <= 3'h0;
         supply_sync <= 3'h7;
      end
      else
      begin
         button_sync <= {button_sync[1:0], power_cycle_button};
         supply_sync <= {supply_sync[1:0], supply_good};
      end
   end

   // Accept a change once stages two and three agree
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         button_state <= 1'b0;
         supply_state <= 1'b1;
         power_cycle  <= 1'b0;
      end
      else
      begin
         power_cycle <= 1'b0;
         if (button_sync[1] == button_sync[2])
         begin
            button_state <= button_sync[2];
            // Release counts as restoring power
            if (button_state && !button_sync[2])
               power_cycle <= 1'b1; // R21
         end
         if (supply_sync[1] == supply_sync[2])
         begin
            supply_state <= supply_sync[2];
            if (!supply_state && supply_sync[2])
               power_cycle <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// File: hw/light_commissioning_fsm.sv
// Commissioning and indication state machine for a networked light
//
// How it works
// R1: Factory-fresh device starts in active search
// R2: Power cycle when off-network starts active search
// R3: Off-network keeps slow periodic scans running
// R4: Search states give plain lamp output
// R5: Search times out to off-network
// R6: Network found during search enters join
// R7: Power cycle during search restarts timer
// R8: Join flashes ten times then on-network
// R9: Power cycle in join still reaches on-network
// R10: On-network follows network light commands
// R11: Stored network rejoined after power return
// R12: Burst of four enters identify
// R13: Burst of five to nine enters status
// R14: Ten cycles or leave command enters leave
// R15: Identify blinks 0.5 Hz, exits on timer/cycle
// R16: Local identify lasts three minutes
// R17: Remote identify lasts requested duration
// R18: Status blinks 2 Hz, exits on timer/cycle
// R19: Leave drops network, three slow flashes, search
// R20: Power cycle in leave still reaches search
// R21: Button press/release counts as power cycle
// R22: Bursts counted only within short window
// R23: Burst window and status timeout are parameters
// R24: Joined and first-power flags are non-volatile
`timescale 1ns/1ps
`default_nettype none

module light_commissioning_fsm
   import light_commissioning_pkg::*;
#(
   parameter int unsigned SEARCH_MS_P    = light_commissioning_pkg::SEARCH_MS,
   parameter int unsigned IDENTIFY_MS_P  = light_commissioning_pkg::IDENTIFY_MS,
   parameter int unsigned STATUS_MS_P    = light_commissioning_pkg::STATUS_MS,
   parameter int unsigned BURST_MS_P     = light_commissioning_pkg::BURST_WINDOW_MS,
   parameter int unsigned SCAN_PERIOD_P  = light_commissioning_pkg::SCAN_PERIOD_MS,
   parameter int unsigned MS_CYCLES_P    = light_commissioning_pkg::MS_CYCLES,
   parameter int unsigned SLOW_HALF_P    = light_commissioning_pkg::SLOW_HALF_MS,
   parameter int unsigned FAST_HALF_P    = light_commissioning_pkg::FAST_HALF_MS
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Power-cycle sources
   input  wire logic        power_cycle_button,
   input  wire logic        supply_good,
   // Non-volatile store
   input  wire logic        nv_joined,
   input  wire logic        nv_commissioned,
   output logic             nv_write,
   output logic             nv_joined_wr,
   output logic             nv_commissioned_wr,
   // Network stack
   input  wire logic        network_found,
   input  wire logic        leave_command,
   input  wire logic        identify_command,
   input  wire logic [15:0] identify_seconds,
   input  wire logic [5:0]  network_light,
   output logic             search_active,
   output logic             search_slow,
   output logic             leave_request,
   output logic             rejoin_request,
   // Light input and outputs
   input  wire logic [5:0]  local_light,
   output logic [5:0]       light_out,
   output logic             status_led,
   output logic [2:0]       state_out
);
   import light_commissioning_pkg::*;

   initial
   begin
      if (MS_CYCLES_P < 1 || SLOW_HALF_P < 1 || FAST_HALF_P < 1 || BURST_MS_P < 1)
         $error("light_commissioning_fsm: timing parameters must be nonzero");
   end

   // ------------------------------------------------------------
   // Millisecond tick
   // ------------------------------------------------------------
   logic [31:0] ms_div;
   logic        ms_tick;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         ms_div  <= 32'h0;
         ms_tick <= 1'b0;
      end
      else if (ms_div >= 32'(MS_CYCLES_P - 1))
      begin
         ms_div  <= 32'h0;
         ms_tick <= 1'b1;
      end
      else
      begin
         ms_div  <= ms_div + 32'h1;
         ms_tick <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Power-cycle events
   // ------------------------------------------------------------
   logic power_cycle;

   power_cycle_detect u_detect
   (
      .clk                (clk),
      .reset_n            (reset_n),
      .power_cycle_button (power_cycle_button),
      .supply_good        (supply_good),
      .power_cycle        (power_cycle)
   );

   // ------------------------------------------------------------
   // Burst counter
   // ------------------------------------------------------------
   commission_state_t state;
   logic [3:0]  burst_count;
   logic [31:0] burst_ms;
   logic        burst_done;

   // A burst closes once the window passes with no further cycle
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         burst_count <= 4'h0;
         burst_ms    <= 32'h0;
         burst_done  <= 1'b0;
      end
      else
      begin
         burst_done <= 1'b0;
         if (state != ST_ON_NETWORK)
         begin
            burst_count <= 4'h0;
            burst_ms    <= 32'h0;
         end
         else if (power_cycle)
         begin
            if (burst_count != 4'hf)
               burst_count <= burst_count + 4'h1;
            burst_ms <= 32'h0; // R22
         end
         else if (burst_count != 4'h0 && ms_tick)
         begin
            if (burst_ms >= 32'(BURST_MS_P - 1)) // R22 R23
            begin
               burst_done <= 1'b1;
               burst_ms   <= 32'h0;
            end
            else
               burst_ms <= burst_ms + 32'h1;
         end
         if (burst_done)
            burst_count <= 4'h0;
      end
   end

   // ------------------------------------------------------------
   // State timer and flash pattern
   // ------------------------------------------------------------
   logic [31:0] timer_ms;
   logic [31:0] phase_ms;
   logic        blink;
   logic [4:0]  flash_count;
   logic        load_timer;
   logic [31:0] load_value;
   logic [31:0] half_ms;
   logic        timer_done;

   assign timer_done = (timer_ms == 32'h0);
   assign half_ms = (state == ST_STATUS) ? 32'(FAST_HALF_P) : 32'(SLOW_HALF_P);

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         timer_ms <= 32'h0;
      else if (load_timer)
         timer_ms <= load_value;
      else if (ms_tick && !timer_done)
         timer_ms <= timer_ms - 32'h1;
   end

   // Blink square wave; one flash is one full period
   always_ff @(posedge clk)
   begin
      if (!reset_n || load_timer)
      begin
         phase_ms    <= 32'h0;
         blink       <= 1'b0;
         flash_count <= 5'h0;
      end
      else if (ms_tick)
      begin
         if (phase_ms >= half_ms - 32'h1)
         begin
            phase_ms <= 32'h0;
            blink    <= ~blink;
            if (blink && flash_count != 5'h1f)
               flash_count <= flash_count + 5'h1;
         end
         else
            phase_ms <= phase_ms + 32'h1;
      end
   end

   // ------------------------------------------------------------
   // Main state machine
   // ------------------------------------------------------------
   commission_state_t next_state;
   logic started;

   always_comb
   begin
      next_state = state;
      load_timer = 1'b0;
      load_value = 32'h0;
      case (state)
         ST_OFF_NETWORK:
            if (power_cycle || network_found)
            begin
               // Infrequent scans may also find a network
               next_state = network_found ? ST_JOIN : ST_ACTIVE_SEARCH; // R2 R3
               load_timer = 1'b1;
               load_value = 32'(SEARCH_MS_P);
            end
         ST_ACTIVE_SEARCH:
            if (network_found)
            begin
               next_state = ST_JOIN; // R6
               load_timer = 1'b1;
            end
            else if (power_cycle)
            begin
               load_timer = 1'b1; // R7
               load_value = 32'(SEARCH_MS_P);
            end
            else if (timer_done)
            begin
               next_state = ST_OFF_NETWORK; // R5
               load_timer = 1'b1;
               load_value = 32'(SCAN_PERIOD_P);
            end
         ST_JOIN:
            if (power_cycle || flash_count >= JOIN_FLASHES)
            begin
               next_state = ST_ON_NETWORK; // R8 R9
               load_timer = 1'b1;
            end
         ST_ON_NETWORK:
            if (leave_command || (power_cycle && burst_count == BURST_LEAVE - 4'h1))
            begin
               next_state = ST_LEAVE; // R14
               load_timer = 1'b1;
            end
            else if (identify_command)
            begin
               next_state = ST_IDENTIFY; // R17
               load_timer = 1'b1;
               load_value = 32'(identify_seconds) * 32'd1000;
            end
            else if (burst_done && burst_count == BURST_IDENTIFY)
            begin
               next_state = ST_IDENTIFY; // R12 R16
               load_timer = 1'b1;
               load_value = 32'(IDENTIFY_MS_P);
            end
            else if (burst_done && burst_count >= BURST_STATUS_LO && burst_count <= BURST_STATUS_HI)
            begin
               next_state = ST_STATUS; // R13 R23
               load_timer = 1'b1;
               load_value = 32'(STATUS_MS_P);
            end
         ST_IDENTIFY:
            if (identify_command)
            begin
               load_timer = 1'b1; // R17
               load_value = 32'(identify_seconds) * 32'd1000;
            end
            else if (power_cycle || timer_done)
            begin
               next_state = ST_ON_NETWORK; // R15
               load_timer = 1'b1;
            end
         ST_STATUS:
            if (power_cycle || timer_done)
            begin
               next_state = ST_ON_NETWORK; // R18
               load_timer = 1'b1;
            end
         ST_LEAVE:
            if (power_cycle || flash_count >= LEAVE_FLASHES)
            begin
               next_state = ST_ACTIVE_SEARCH; // R19 R20
               load_timer = 1'b1;
               load_value = 32'(SEARCH_MS_P);
            end
         default:
         begin
            next_state = ST_OFF_NETWORK;
            load_timer = 1'b1;
         end
      endcase
      // Power-up decision once stored flags have been read
      if (!started)
      begin
         load_timer = 1'b1;
         if (nv_joined)
         begin
            next_state = ST_ON_NETWORK; // R11
            load_value = 32'h0;
         end
         else if (!nv_commissioned)
         begin
            next_state = ST_ACTIVE_SEARCH; // R1
            load_value = 32'(SEARCH_MS_P);
         end
         else
         begin
            next_state = ST_OFF_NETWORK;
            load_value = 32'(SCAN_PERIOD_P);
         end
      end
      // Off-network scan timer reloads itself
      if (started && state == ST_OFF_NETWORK && next_state == ST_OFF_NETWORK && timer_done)
      begin
         load_timer = 1'b1; // R3
         load_value = 32'(SCAN_PERIOD_P);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state   <= ST_OFF_NETWORK;
         started <= 1'b0;
      end
      else
      begin
         state   <= next_state;
         started <= 1'b1;
      end
   end

   // Scan burst kept inside the period, so short test periods still scan
   localparam int unsigned SCAN_ON_P = (SCAN_ON_MS < SCAN_PERIOD_P / 2) ? SCAN_ON_MS : SCAN_PERIOD_P / 2;

   // ------------------------------------------------------------
   // Network stack and store outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         search_active      <= 1'b0;
         search_slow        <= 1'b0;
         leave_request      <= 1'b0;
         rejoin_request     <= 1'b0;
         nv_write           <= 1'b0;
         nv_joined_wr       <= 1'b0;
         nv_commissioned_wr <= 1'b0;
      end
      else
      begin
         search_active  <= (next_state == ST_ACTIVE_SEARCH);
         // Short scan at the start of each slow period
         search_slow    <= (next_state == ST_OFF_NETWORK) &&
                           (timer_ms > 32'(SCAN_PERIOD_P) - 32'(SCAN_ON_P)); // R3
         leave_request  <= (state != ST_LEAVE) && (next_state == ST_LEAVE); // R19
         rejoin_request <= !started && nv_joined; // R11
         // Store at power-up and on each entry to on-network or leave
         nv_write       <= !started ||
                           (state != next_state && (next_state == ST_ON_NETWORK || next_state == ST_LEAVE));
         nv_joined_wr   <= (next_state == ST_ON_NETWORK) || (!started && nv_joined) ||
                           (next_state == ST_IDENTIFY) || (next_state == ST_STATUS); // R24
         nv_commissioned_wr <= 1'b1; // R24
      end
   end

   // ------------------------------------------------------------
   // Light outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         light_out  <= LIGHT_RESET;
         status_led <= 1'b0;
         state_out  <= 3'h0;
      end
      else
      begin
         state_out  <= state;
         status_led <= (state != ST_OFF_NETWORK) && (state != ST_ACTIVE_SEARCH) && (state != ST_LEAVE);
         case (state)
            ST_OFF_NETWORK, ST_ACTIVE_SEARCH:
               light_out <= local_light; // R4
            ST_ON_NETWORK:
               light_out <= network_light; // R10
            ST_JOIN, ST_IDENTIFY, ST_STATUS, ST_LEAVE:
               light_out <= {6{blink}}; // R8 R15 R18 R19
            default:
               light_out <= LIGHT_RESET;
         endcase
      end
   end

endmodule

`default_nettype wire

// File: dv/light_commissioning_assertions.sv
// Port-level assertions for the light commissioning state machine
`timescale 1ns/1ps
`default_nettype none
module light_commissioning_checker
   import light_commissioning_pkg::*;
#(
   parameter int unsigned SEARCH_MS_P = 20,
   parameter int unsigned MS_CYCLES_P = 10,
   parameter int unsigned SLOW_HALF_P = 2
)
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       reset_n,
   // Block inputs
   input wire logic       power_cycle_button,
   input wire logic       supply_good,
   input wire logic       nv_joined,
   input wire logic       nv_commissioned,
   input wire logic       network_found,
   input wire logic       leave_command,
   input wire logic [5:0] local_light,
   // Block outputs
   input wire logic       search_active,
   input wire logic       search_slow,
   input wire logic       leave_request,
   input wire logic [5:0] light_out,
   input wire logic [2:0] state_out
);
   // Slack covers the free-running millisecond tick phase
   localparam int unsigned SLACK      = 2 * MS_CYCLES_P;
   localparam int unsigned FLASH      = 4 * SLOW_HALF_P * MS_CYCLES_P / 2;
   localparam int unsigned SEARCH_LIM = SEARCH_MS_P * MS_CYCLES_P + SLACK;
   localparam int unsigned JOIN_LIM   = 10 * FLASH + SLACK;
   localparam int unsigned LEAVE_LIM  = 3 * FLASH + SLACK;

   int unsigned dwell;

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   // ----------------------------------------
   // Dwell since state or a power pin moved
   // ----------------------------------------
   always_ff @(posedge clk)
      if (!reset_n || $changed(state_out) || $changed(power_cycle_button) || $changed(supply_good))
         dwell <= 0;
      else
         dwell <= dwell + 1;

   property p_first_power;
      $rose(reset_n) && !nv_joined && !nv_commissioned |-> ##[1:4] state_out == ST_ACTIVE_SEARCH;
   endproperty
   a_first_power: assert property (p_first_power)
      else $error("fresh device did not start searching");
   property p_search_lim;
      state_out == ST_ACTIVE_SEARCH |-> dwell <= SEARCH_LIM;
   endproperty
   a_search_lim: assert property (p_search_lim)
      else $error("search outlived its timer");
   property p_join_lim;
      state_out == ST_JOIN |-> dwell <= JOIN_LIM;
   endproperty
   a_join_lim: assert property (p_join_lim)
      else $error("join flashing too long");
   property p_leave_lim;
      state_out == ST_LEAVE |-> dwell <= LEAVE_LIM;
   endproperty
   a_leave_lim: assert property (p_leave_lim)
      else $error("leave flashing too long");
   property p_found;
      state_out == ST_ACTIVE_SEARCH && network_found |-> ##[1:3] state_out == ST_JOIN;
   endproperty
   a_found: assert property (p_found)
      else $error("found network did not start join");
   property p_leave_cmd;
      state_out == ST_ON_NETWORK && leave_command |-> ##[1:3] state_out == ST_LEAVE;
   endproperty
   a_leave_cmd: assert property (p_leave_cmd)
      else $error("leave command ignored");
   property p_leave_pulse;
      leave_request |=> !leave_request ##[0:1] state_out == ST_LEAVE;
   endproperty
   a_leave_pulse: assert property (p_leave_pulse)
      else $error("leave request not a single pulse into leave");
   property p_plain_lamp;
      $past(reset_n, 2) && state_out inside {ST_OFF_NETWORK, ST_ACTIVE_SEARCH}
         && $past(state_out) == state_out && $stable(local_light) |-> light_out == local_light;
   endproperty
   a_plain_lamp: assert property (p_plain_lamp)
      else $error("lamp output not plain while unjoined");
   property p_no_search;
      state_out == ST_ON_NETWORK && $past(state_out) == ST_ON_NETWORK |-> !search_active && !search_slow;
   endproperty
   a_no_search: assert property (p_no_search)
      else $error("searching while joined");

   c_join: cover property (state_out == ST_JOIN);
   c_identify: cover property (state_out == ST_IDENTIFY);
   c_status: cover property (state_out == ST_STATUS);
endmodule

bind light_commissioning_fsm light_commissioning_checker #(
   .SEARCH_MS_P(SEARCH_MS_P),
   .MS_CYCLES_P(MS_CYCLES_P),
   .SLOW_HALF_P(SLOW_HALF_P)
) checker_i (.*);
`default_nettype wire

// File: dv/network_stack_model.sv
// Behavioural network stack and gateway facing the light
`timescale 1ns/1ps
`default_nettype none
module network_stack_model
(
   // Clock
   input  wire logic        clk,
   // Bench commands
   input  wire logic        find_en,
   input  wire logic [9:0]  find_delay,
   input  wire logic        send_leave,
   input  wire logic        send_identify,
   input  wire logic [15:0] ident_secs,
   input  wire logic [5:0]  light_cmd,
   // Device side
   input  wire logic        search_active,
   input  wire logic        search_slow,
   output logic             network_found,
   output logic             leave_command,
   output logic             identify_command,
   output logic [15:0]      identify_seconds,
   output logic [5:0]       network_light
);
   logic [9:0] wait_cnt = 10'h000;

   initial
   begin
      network_found = 1'b0;
      leave_command = 1'b0;
      identify_command = 1'b0;
      identify_seconds = 16'h0000;
      network_light = 6'h00;
   end

   // A network only answers a device that is scanning
   always @(posedge clk)
   begin
      network_found <= 1'b0;
      wait_cnt <= 10'h000;
      if (find_en && (search_active || search_slow))
      begin
         wait_cnt <= wait_cnt + 10'h001;
         network_found <= (wait_cnt == find_delay);
      end
      leave_command <= send_leave;
      identify_command <= send_identify;
      identify_seconds <= send_identify ? ident_secs : ~identify_seconds;
      network_light <= light_cmd;
   end
endmodule
`default_nettype wire

// File: dv/light_commissioning_fsm_tb.sv
// Self-checking bench for the light commissioning state machine
`timescale 1ns/1ps
`default_nettype none
module light_commissioning_fsm_tb;
   import light_commissioning_pkg::*;

   typedef struct {int n; commission_state_t st;} burst_row_t;

   logic clk = 1'b0, reset_n = 1'b0, power_cycle_button = 1'b0, supply_good = 1'b1;
   logic nv_joined = 1'b0, nv_commissioned = 1'b0;
   logic find_en = 1'b0, send_leave = 1'b0, send_identify = 1'b0;
   logic [9:0] find_delay = 10'h005;
   logic [15:0] ident_secs = 16'h0000, identify_seconds;
   logic [5:0] light_cmd = 6'h00, local_light = 6'h15, network_light, light_out;
   logic network_found, leave_command, identify_command, nv_write, nv_joined_wr, nv_commissioned_wr;
   logic search_active, search_slow, leave_request, rejoin_request, status_led;
   logic [2:0] state_out;
   logic saw_leave = 1'b0, saw_rejoin = 1'b0, saw_store = 1'b0;
   int fails = 0, tests_run = 0, cycles = 0, n;
   burst_row_t rows [6] = '{
      '{1, ST_ON_NETWORK}, '{3, ST_ON_NETWORK},
      '{4, ST_IDENTIFY},
      '{5, ST_STATUS}, '{9, ST_STATUS},
      '{10, ST_LEAVE}};

   light_commissioning_fsm #(.SEARCH_MS_P(20), .IDENTIFY_MS_P(30), .STATUS_MS_P(20), .BURST_MS_P(5),
      .SCAN_PERIOD_P(50), .MS_CYCLES_P(10), .SLOW_HALF_P(2), .FAST_HALF_P(1)) light_commissioning_fsm_i (.*);

   network_stack_model network_stack_model_i (.*);

   always #5 clk = ~clk;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1)
      begin
         fails++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   task automatic restart(input logic joined);
      reset_n = 1'b0;
      nv_joined = joined;
      nv_commissioned = joined;
      tick(2);
      reset_n = 1'b1;
      tick(4);
   endtask

   // Button press is power loss, release is power return
   task automatic pulse(input int k);
      repeat (k)
      begin
         power_cycle_button = 1'b1;
         tick(3);
         power_cycle_button = 1'b0;
         tick(3);
      end
   endtask

   task automatic dwell(input logic [2:0] st, input int lim);
      n = 0;
      while (state_out === st && n < lim)
      begin
         tick(1);
         n++;
      end
   endtask

   task automatic test_done;
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      saw_leave <= saw_leave | (leave_request === 1'b1);
      saw_rejoin <= saw_rejoin | (rejoin_request === 1'b1);
      saw_store <= saw_store | (nv_write === 1'b1 && nv_joined_wr === 1'b1);
      cycles++;
      if (cycles == 40000)
      begin
         fails++;
         test_done();
      end
   end

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      foreach (rows[i])
      begin
         restart(1'b1);
         pulse(rows[i].n);
         tick(80);
         check(state_out === rows[i].st, "burst outcome");
      end
      check(saw_rejoin === 1'b1, "no rejoin at power-up");
      pulse(1);
      tick(6);
      check(state_out === ST_ACTIVE_SEARCH, "leave cut short");
      restart(1'b0);
      check(state_out === ST_ACTIVE_SEARCH, "fresh start");
      local_light = 6'h2c;
      tick(2);
      check(light_out === 6'h2c, "plain lamp");
      dwell(ST_ACTIVE_SEARCH, 400);
      check(state_out === ST_OFF_NETWORK && n inside {[180:220]}, "search timeout");
      dwell(ST_OFF_NETWORK, 600);
      check(search_slow === 1'b1, "no slow scan");
      supply_good = 1'b0;
      tick(4);
      supply_good = 1'b1;
      tick(8);
      check(state_out === ST_ACTIVE_SEARCH, "supply cycle");
      tick(150);
      pulse(1);
      tick(120);
      check(state_out === ST_ACTIVE_SEARCH, "timer restart");
      find_en = 1'b1;
      tick(10);
      find_en = 1'b0;
      check(state_out === ST_JOIN, "join");
      dwell(ST_JOIN, 500);
      check(state_out === ST_ON_NETWORK && n inside {[380:420]}, "ten flashes");
      check(saw_store === 1'b1, "joined flag not stored");
      light_cmd = 6'h33;
      tick(4);
      check(light_out === 6'h33 && search_active === 1'b0, "network light");
      send_leave = 1'b1;
      tick(1);
      send_leave = 1'b0;
      tick(4);
      check(state_out === ST_LEAVE && saw_leave === 1'b1, "leave command");
      dwell(ST_LEAVE, 300);
      check(state_out === ST_ACTIVE_SEARCH && n inside {[100:130]}, "three slow flashes");
      find_delay = 10'h003;
      find_en = 1'b1;
      tick(10);
      find_en = 1'b0;
      pulse(1);
      tick(6);
      check(state_out === ST_ON_NETWORK, "join cut short");
      pulse(4);
      tick(80);
      pulse(1);
      tick(6);
      check(state_out === ST_ON_NETWORK, "identify exit by cycle");
      restart(1'b1);
      pulse(4);
      tick(80);
      dwell(ST_IDENTIFY, 400);
      check(state_out === ST_ON_NETWORK && n inside {[250:310]}, "local identify time");
      pulse(5);
      tick(80);
      dwell(ST_STATUS, 300);
      check(state_out === ST_ON_NETWORK && n inside {[150:210]}, "status time");
      ident_secs = 16'h0001;
      send_identify = 1'b1;
      tick(1);
      send_identify = 1'b0;
      tick(4);
      dwell(ST_IDENTIFY, 11000);
      check(state_out === ST_ON_NETWORK && n inside {[9900:10100]}, "remote identify time");
      test_done();
   end
endmodule
`default_nettype wire
